/* core/cso_core_regs.sv */
// core status, option and interrupt control register group
//
// Operation
// - status write by a flag-affecting instruction keeps the flags it owns from the result (z, dc, c for add and subtract)
// - timeout and powerdown flags ignore instruction writes
// - indirect bank select picks upper 256 bytes when set, lower when clear
// - two-bit direct bank field selects one of four 128-byte banks
// - timeout flag set by power-up, watchdog clear, sleep; cleared by timeout
// - powerdown flag set by power-up or watchdog clear; cleared by sleep
// - zero flag follows whether the result is zero
// - nibble carry is carry out of bit 3, inverted borrow on subtract
// - carry is msb carry out, inverted borrow; rotates load shifted-out bit
// - status register reachable at all four bank addresses
// - option at 81h/181h, reset ones; bit 7 disables pull-ups, else latch-driven
// - option bit 6 picks rising or falling external interrupt edge
// - option bit 5 picks external pin or instruction clock for timer 0
// - option bit 4 picks falling or rising external timer edge
// - option bit 3 gives prescaler to watchdog, timer 0 then runs 1:1
// - ratio field gives timer 0 2^(n+1) and watchdog 2^n
// - interrupt flags set regardless of their enables
// - irq control mirrored in all banks; global and peripheral gates
// - timer 0 overflow sets its flag; software clears it
// - external pin event sets its flag; software clears it
// - change on upper four port pins sets its flag; software clears it
// - peripheral enable register at 8Ch resets zero, bit 3 reads zero
// - peripheral flags at 0Ch, serial rx and tx flags read-only
`timescale 1ns/1ps
`default_nettype none
`include "cso_map.svh"
module cso_core_regs
    import cso_pkg::*;
(
    // clock and reset
    input  wire logic       CLOCK,
    input  wire logic       RESET,
    // register access from instruction execution
    input  wire logic [8:0] ADDR,
    input  wire logic       WR_EN,
    input  wire logic [7:0] WR_DATA,
    output logic      [7:0] RD_DATA,
    // executing operation and core events
    input  wire cso_alu_s   ALU,
    input  wire cso_evt_s   EVT,
    // pins and peripheral event sources
    input  wire logic       EXT_IRQ_PIN,
    input  wire logic       EXT_TIMER_PIN,
    input  wire logic [3:0] UPPER_PORT_PINS,
    input  wire logic [7:0] PORT_LATCH,
    input  wire logic [7:0] PERIPH_EVT,
    // data memory addressing
    input  wire logic [7:0] FSR,
    input  wire logic [6:0] DIR_OFFSET,
    output logic      [8:0] INDIRECT_ADDR,
    output logic      [8:0] DIRECT_ADDR,
    // timer, watchdog and port controls
    output logic      [7:0] PULLUP_EN,
    output logic            TIMER0_TICK,
    output logic      [3:0] T0_DIV_LOG2,
    output logic      [2:0] WDT_DIV_LOG2,
    // interrupt request to the core
    output logic            IRQ_REQ
);
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] option_reg;
    logic [7:0] irq_core_control_reg;
    logic [7:0] irq_core_control_next;
    logic [7:0] pie_reg;
    logic [7:0] pir_reg;
    logic [7:0] pir_next;
    logic [3:0] upper_q_reg;
    logic       upper_primed_reg;
    logic       st_wr;
    logic       op_wr;
    logic       ic_wr;
    logic       pie_wr;
    logic       pir_wr;
    logic       ext_hit;
    logic       t0_pin_hit;
    logic       port_change;
    cso_flags_t alu_f;
    cso_flags_t alu_m;

    // flags produced by an operation; subtract adds the two's complement
    function automatic cso_flags_t alu_flags(input cso_alu_s x);
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] n;
        logic       cin;
        bb  = (x.op == CSO_ALU_SUB) ? ~x.b : x.b;
        cin = (x.op == CSO_ALU_SUB);
        s   = {1'b0, x.a} + {1'b0, bb} + {8'h00, cin};
        n   = {1'b0, x.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
        case (x.op)
            CSO_ALU_ADD,
            CSO_ALU_SUB:   alu_flags = {(s[7:0] == 8'h00), n[4], s[8]};
            CSO_ALU_LOGIC: alu_flags = {(x.b == 8'h00), 2'b00};
            CSO_ALU_RLF:   alu_flags = {2'b00, x.a[7]};
            CSO_ALU_RRF:   alu_flags = {2'b00, x.a[0]};
            default:       alu_flags = 3'b000;
        endcase
    endfunction

    // which of z, dc, c the operation owns
    function automatic cso_flags_t alu_mask(input cso_alu_op_e op);
        case (op)
            CSO_ALU_ADD,
            CSO_ALU_SUB:   alu_mask = 3'b111;
            CSO_ALU_LOGIC: alu_mask = 3'b100;
            CSO_ALU_RLF,
            CSO_ALU_RRF:   alu_mask = 3'b001;
            default:       alu_mask = 3'b000;
        endcase
    endfunction

    // data memory address from a bank field and an offset
    function automatic logic [8:0] bank_addr(input logic [1:0] bank, input logic [6:0] off);
        bank_addr = {bank, off};
    endfunction

    assign alu_f = alu_flags(ALU);
    assign alu_m = alu_mask(ALU.op);

    // address decode; status and irq control ignore both bank bits, option only the upper one
    assign st_wr  = WR_EN & (ADDR[6:0] == `CSO_ADR_STATUS);
    assign op_wr  = WR_EN & (ADDR[7:0] == `CSO_ADR_OPTION);
    assign ic_wr  = WR_EN & (ADDR[6:0] == `CSO_ADR_IRQ_CORE_CONTROL);
    assign pie_wr = WR_EN & (ADDR == `CSO_ADR_PIE);
    assign pir_wr = WR_EN & (ADDR == `CSO_ADR_PIR);

    // edge detectors for the external interrupt pin and the timer input
    cso_edge_det u_ext_edge (
        .CLOCK    (CLOCK),
        .RESET    (RESET),
        .pin      (EXT_IRQ_PIN),
        .rise_sel (option_reg[`CSO_OP_EXT_IRQ_EDGE_SEL]),
        .hit      (ext_hit)
    );

    cso_edge_det u_t0_edge (
        .CLOCK    (CLOCK),
        .RESET    (RESET),
        .pin      (EXT_TIMER_PIN),
        .rise_sel (~option_reg[`CSO_OP_T0EDGE]),
        .hit      (t0_pin_hit)
    );

    // status next value: software bits, then alu result, then hardware events
    always_comb begin
        status_next = status_reg;
        if (st_wr) begin
            status_next[`CSO_ST_IRP:`CSO_ST_RP_LO] = WR_DATA[`CSO_ST_IRP:`CSO_ST_RP_LO];
            status_next[`CSO_ST_Z:`CSO_ST_C]       = WR_DATA[`CSO_ST_Z:`CSO_ST_C];
        end
        // the result overrides the written value bit by bit
        for (int i = 0; i < 3; i++) begin
            if (alu_m[i]) begin
                status_next[i] = alu_f[i];
            end
        end
        if (EVT.wdt_clr) begin
            status_next[`CSO_ST_TO] = 1'b1;
            status_next[`CSO_ST_PD] = 1'b1;
        end
        if (EVT.sleep) begin
            status_next[`CSO_ST_TO] = 1'b1;
            status_next[`CSO_ST_PD] = 1'b0;
        end
        // a timeout must not be hidden by a coincident clear
        if (EVT.wdt_timeout) begin
            status_next[`CSO_ST_TO] = 1'b0;
        end
    end

    // status register; power-up leaves timeout and powerdown set
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            status_reg <= `CSO_RST_STATUS;
        end else begin
            status_reg <= status_next;
        end
    end

    // option register, all ones after power-up
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            option_reg <= `CSO_RST_OPTION;
        end else if (op_wr) begin
            option_reg <= WR_DATA;
        end
    end

    // port change seen against the previous sample of the upper pins
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            upper_q_reg      <= 4'h0;
            upper_primed_reg <= 1'b0;
        end else begin
            upper_q_reg      <= UPPER_PORT_PINS;
            upper_primed_reg <= 1'b1;
        end
    end

    assign port_change = upper_primed_reg & (|(UPPER_PORT_PINS ^ upper_q_reg));

    // irq control: write first, events or in after so a set beats a clear
    always_comb begin
        irq_core_control_next = ic_wr ? WR_DATA : irq_core_control_reg;
        irq_core_control_next[`CSO_IC_TIMER0_OVF_FLAG] = irq_core_control_next[`CSO_IC_TIMER0_OVF_FLAG] | EVT.t0_ovf;
        irq_core_control_next[`CSO_IC_EXT_IRQ_FLAG] = irq_core_control_next[`CSO_IC_EXT_IRQ_FLAG] | ext_hit;
        irq_core_control_next[`CSO_IC_PORT_CHANGE_FLAG] = irq_core_control_next[`CSO_IC_PORT_CHANGE_FLAG] | port_change;
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            irq_core_control_reg <= `CSO_RST_IRQ_CORE_CONTROL;
        end else begin
            irq_core_control_reg <= irq_core_control_next;
        end
    end

    // peripheral enables; the unused bit is held at zero
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            pie_reg <= `CSO_RST_PIE;
        end else if (pie_wr) begin
            pie_reg <= WR_DATA & `CSO_PIE_MASK;
        end
    end

    // peripheral flags: sticky with set winning; serial flags follow their source
    always_comb begin
        pir_next = pir_reg;
        if (pir_wr) begin
            pir_next = (pir_reg & ~`CSO_PIR_SW_MASK) | (WR_DATA & `CSO_PIR_SW_MASK);
        end
        pir_next = (pir_next | PERIPH_EVT) & `CSO_PIR_SW_MASK;
        pir_next[`CSO_PR_RX] = PERIPH_EVT[`CSO_PR_RX];
        pir_next[`CSO_PR_TX] = PERIPH_EVT[`CSO_PR_TX];
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            pir_reg <= `CSO_RST_PIR;
        end else begin
            pir_reg <= pir_next;
        end
    end

    // read port, one cycle behind the address; unmapped addresses read zero
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            RD_DATA <= `CSO_RST_ZERO8;
        end else if (ADDR[6:0] == `CSO_ADR_STATUS) begin
            RD_DATA <= status_reg;
        end else if (ADDR[6:0] == `CSO_ADR_IRQ_CORE_CONTROL) begin
            RD_DATA <= irq_core_control_reg;
        end else if (ADDR[7:0] == `CSO_ADR_OPTION) begin
            RD_DATA <= option_reg;
        end else if (ADDR == `CSO_ADR_PIE) begin
            RD_DATA <= pie_reg;
        end else if (ADDR == `CSO_ADR_PIR) begin
            RD_DATA <= pir_reg;
        end else begin
            RD_DATA <= `CSO_RST_ZERO8;
        end
    end

    // data memory addresses from the bank selects
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            INDIRECT_ADDR <= 9'h000;
            DIRECT_ADDR   <= 9'h000;
        end else begin
            INDIRECT_ADDR <= {status_reg[`CSO_ST_IRP], FSR};
            DIRECT_ADDR   <= bank_addr(status_reg[`CSO_ST_RP_HI:`CSO_ST_RP_LO], DIR_OFFSET);
        end
    end

    // pull-ups follow the port latch unless disabled
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            PULLUP_EN <= `CSO_RST_ZERO8;
        end else if (option_reg[`CSO_OP_PU_DIS]) begin
            PULLUP_EN <= `CSO_RST_ZERO8;
        end else begin
            PULLUP_EN <= PORT_LATCH;
        end
    end

    // timer 0 source: every instruction cycle or a selected pin edge
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            TIMER0_TICK <= 1'b0;
        end else begin
            TIMER0_TICK <= option_reg[`CSO_OP_T0SRC] ? t0_pin_hit : 1'b1;
        end
    end

    // prescaler division, as a power of two; the unowned side runs 1:1
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            T0_DIV_LOG2  <= 4'h0;
            WDT_DIV_LOG2 <= 3'h0;
        end else if (option_reg[`CSO_OP_PSA]) begin
            T0_DIV_LOG2  <= 4'h0;
            WDT_DIV_LOG2 <= option_reg[`CSO_OP_PS_HI:`CSO_OP_PS_LO];
        end else begin
            T0_DIV_LOG2  <= {1'b0, option_reg[`CSO_OP_PS_HI:`CSO_OP_PS_LO]} + 4'h1;
            WDT_DIV_LOG2 <= 3'h0;
        end
    end

    // request needs global enable; peripheral pairs also need their gate
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            IRQ_REQ <= 1'b0;
        end else begin
            IRQ_REQ <= irq_core_control_reg[`CSO_IC_GIE] & (
                (irq_core_control_reg[`CSO_IC_TIMER0_OVF_FLAG] & irq_core_control_reg[`CSO_IC_TIMER0_OVF_EN]) |
                (irq_core_control_reg[`CSO_IC_EXT_IRQ_FLAG] & irq_core_control_reg[`CSO_IC_EXT_IRQ_EN]) |
                (irq_core_control_reg[`CSO_IC_PORT_CHANGE_FLAG] & irq_core_control_reg[`CSO_IC_PORT_CHANGE_EN]) |
                (irq_core_control_reg[`CSO_IC_PERIPH_IRQ_EN] & (|(pir_reg & pie_reg))));
        end
    end

    // checks on the behaviour above
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    property p_alu_wins;
        (st_wr && alu_m == 3'b111) |=> status_reg[2:0] == $past(alu_f);
    endproperty
    a_alu_wins: assert property (p_alu_wins) else $error("alu flags lost on status write");

    property p_to_pd_ro;
        (st_wr && !EVT.wdt_clr && !EVT.sleep && !EVT.wdt_timeout)
            |=> $stable(status_reg[`CSO_ST_TO:`CSO_ST_PD]);
    endproperty
    a_to_pd_ro: assert property (p_to_pd_ro) else $error("timeout or powerdown written");

    property p_sleep;
        (EVT.sleep && !EVT.wdt_timeout && !EVT.wdt_clr)
            |=> status_reg[`CSO_ST_TO] && !status_reg[`CSO_ST_PD];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not set flags");

    property p_timeout;
        EVT.wdt_timeout |=> !status_reg[`CSO_ST_TO];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag not cleared");

    property p_add_carry;
        (ALU.op == CSO_ALU_ADD) |=> status_reg[`CSO_ST_C] == ($past(ALU.a) > ~$past(ALU.b));
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

    property p_flag_set;
        EVT.t0_ovf |=> irq_core_control_reg[`CSO_IC_TIMER0_OVF_FLAG];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overflow flag missed");

    property p_irq;
        (irq_core_control_reg[`CSO_IC_GIE] && irq_core_control_reg[`CSO_IC_EXT_IRQ_FLAG] && irq_core_control_reg[`CSO_IC_EXT_IRQ_EN]) |=> IRQ_REQ;
    endproperty
    a_irq: assert property (p_irq) else $error("request not raised");

    property p_no_gie;
        !irq_core_control_reg[`CSO_IC_GIE] |=> !IRQ_REQ;
    endproperty
    a_no_gie: assert property (p_no_gie) else $error("request without global enable");

    property p_psa;
        option_reg[`CSO_OP_PSA] |=> T0_DIV_LOG2 == 4'h0;
    endproperty
    a_psa: assert property (p_psa) else $error("timer 0 scaled while watchdog owns prescaler");

    property p_pie_zero;
        pie_reg[3] == 1'b0;
    endproperty
    a_pie_zero: assert property (p_pie_zero) else $error("reserved enable bit set");

    c_alu_on_write: cover property (st_wr && alu_m != 3'b000);
    c_set_clear:    cover property (ic_wr && !WR_DATA[`CSO_IC_PORT_CHANGE_FLAG] && port_change);
    c_irq:          cover property (!IRQ_REQ ##1 IRQ_REQ);
    c_ext_src:      cover property (option_reg[`CSO_OP_T0SRC] && TIMER0_TICK);
endmodule
`default_nettype wire

/* core/cso_edge_det.sv */
// selectable edge detector for a synchronous pin
`timescale 1ns/1ps
`default_nettype none
module cso_edge_det (
    // clock and reset
    input  wire logic CLOCK,
    input  wire logic RESET,
    // pin and edge choice
    input  wire logic pin,
    input  wire logic rise_sel,
    // one-cycle edge pulse
    output logic      hit
);
    logic pin_q_reg;
    logic primed_reg;

    // previous sample; primed stops a false edge on the first cycle after reset
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            pin_q_reg  <= 1'b0;
            primed_reg <= 1'b0;
        end else begin
            pin_q_reg  <= pin;
            primed_reg <= 1'b1;
        end
    end

    // rising when rise_sel, falling otherwise
    assign hit = primed_reg & (rise_sel ? (pin & ~pin_q_reg) : (~pin & pin_q_reg));
endmodule
`default_nettype wire

/* core/cso_map.svh */
// register addresses, bit positions and reset values of the core status block
`ifndef CSO_MAP_SVH
`define CSO_MAP_SVH
// address decode: status and irq control decode on the low 7 bits (all banks)
`define CSO_ADR_STATUS     7'h03
`define CSO_ADR_IRQ_CORE_CONTROL     7'h0B
// option register decodes on the low 8 bits (81h and 181h)
`define CSO_ADR_OPTION     8'h81
`define CSO_ADR_PIE        9'h08C
`define CSO_ADR_PIR        9'h00C
// status bit positions
`define CSO_ST_IRP         7
`define CSO_ST_RP_HI       6
`define CSO_ST_RP_LO       5
`define CSO_ST_TO          4
`define CSO_ST_PD          3
`define CSO_ST_Z           2
`define CSO_ST_DC          1
`define CSO_ST_C           0
// option bit positions
`define CSO_OP_PU_DIS      7
`define CSO_OP_EXT_IRQ_EDGE_SEL      6
`define CSO_OP_T0SRC       5
`define CSO_OP_T0EDGE      4
`define CSO_OP_PSA         3
`define CSO_OP_PS_HI       2
`define CSO_OP_PS_LO       0
// irq control bit positions
`define CSO_IC_GIE         7
`define CSO_IC_PERIPH_IRQ_EN        6
`define CSO_IC_TIMER0_OVF_EN        5
`define CSO_IC_EXT_IRQ_EN        4
`define CSO_IC_PORT_CHANGE_EN        3
`define CSO_IC_TIMER0_OVF_FLAG        2
`define CSO_IC_EXT_IRQ_FLAG        1
`define CSO_IC_PORT_CHANGE_FLAG        0
// peripheral register bits and masks
`define CSO_PR_RX          5
`define CSO_PR_TX          4
`define CSO_PIE_MASK       8'hF7
`define CSO_PIR_SW_MASK    8'hC7
// reset values
`define CSO_RST_STATUS     8'h18
`define CSO_RST_OPTION     8'hFF
`define CSO_RST_IRQ_CORE_CONTROL     8'h00
`define CSO_RST_PIE        8'h00
`define CSO_RST_PIR        8'h00
`define CSO_RST_ZERO8      8'h00
`define CSO_BANK_ZERO      2'h0
`endif

/* core/cso_pkg.sv */
// types shared by the core status block
package cso_pkg;
    typedef enum logic [2:0] {
        CSO_ALU_NONE  = 3'h0,
        CSO_ALU_ADD   = 3'h1,
        CSO_ALU_SUB   = 3'h3,
        CSO_ALU_LOGIC = 3'h2,
        CSO_ALU_RLF   = 3'h6,
        CSO_ALU_RRF   = 3'h7
    } cso_alu_op_e;

    // operation currently executing in the core
    typedef struct packed {
        cso_alu_op_e op;
        logic [7:0]  a;
        logic [7:0]  b;
    } cso_alu_s;

    // core and watchdog events, one-cycle pulses
    typedef struct packed {
        logic wdt_clr;
        logic sleep;
        logic wdt_timeout;
        logic t0_ovf;
    } cso_evt_s;

    // z, dc, c in status bit order
    typedef logic [2:0] cso_flags_t;
endpackage

/* verif/cso_core_bfm.sv */
// core-side model issuing register accesses, alu operations and events
`timescale 1ns/1ps
`default_nettype none
module cso_core_bfm
    import cso_pkg::*;
(
    // clock and read data
    input  wire logic       CLOCK,
    input  wire logic [7:0] RD_DATA,
    // instruction side
    output logic      [8:0] ADDR,
    output logic            WR_EN,
    output logic      [7:0] WR_DATA,
    output var cso_alu_s    ALU,
    output var cso_evt_s    EVT
);
    // idle at time zero so nothing is decoded before the first access
    initial begin
        ADDR = 9'h000;
        WR_EN = 1'b0;
        WR_DATA = 8'h00;
        ALU = '0;
        EVT = '0;
    end

    // one instruction cycle, driven off the sampling edge
    // flag clears are ordinary writes of zero
    task automatic xfer(input logic [8:0] a, input logic w, input logic [7:0] d,
                        input cso_alu_s al, input cso_evt_s ev, output logic [7:0] q);
        @(negedge CLOCK);
        ADDR = a;
        WR_EN = w;
        WR_DATA = d;
        ALU = al;
        EVT = ev;
        @(negedge CLOCK);
        q = RD_DATA;
        WR_EN = 1'b0;
        ALU = '0;
        EVT = '0;
    endtask
endmodule
`default_nettype wire

/* verif/tb_cso_core_regs.sv */
// self-checking bench for the core status block
`timescale 1ns/1ps
`default_nettype none
module tb_cso_core_regs
    import cso_pkg::*;
;
    logic       CLOCK = 1'b0;
    logic       RESET = 1'b1;
    logic [8:0] ADDR;
    logic       WR_EN;
    logic [7:0] WR_DATA;
    logic [7:0] RD_DATA;
    cso_alu_s   ALU;
    cso_evt_s   EVT;
    logic       EXT_IRQ_PIN = 1'b0;
    logic       EXT_TIMER_PIN = 1'b0;
    logic [3:0] UPPER_PORT_PINS = 4'h0;
    logic [7:0] PORT_LATCH = 8'h00;
    logic [7:0] PERIPH_EVT = 8'h00;
    logic [7:0] FSR = 8'h00;
    logic [6:0] DIR_OFFSET = 7'h00;
    logic [8:0] INDIRECT_ADDR;
    logic [8:0] DIRECT_ADDR;
    logic [7:0] PULLUP_EN;
    logic       TIMER0_TICK;
    logic [3:0] T0_DIV_LOG2;
    logic [2:0] WDT_DIV_LOG2;
    logic       IRQ_REQ;
    int         num_errors = 0;
    int         comparisons = 0;
    int         ticks = 0;
    int         n;
    logic [7:0] st = 8'h18;
    logic [7:0] q;
    logic [7:0] d;
    cso_alu_s   al;
    cso_evt_s   ev;
    cso_alu_op_e ops [5] = '{CSO_ALU_ADD, CSO_ALU_SUB, CSO_ALU_LOGIC, CSO_ALU_RLF, CSO_ALU_RRF};
    logic [3:0] evs [4] = '{4'h2, 4'h4, 4'h2, 4'h8};

    cso_core_regs cso_core_regs_i (.CLOCK, .RESET, .ADDR, .WR_EN, .WR_DATA, .RD_DATA, .ALU, .EVT,
        .EXT_IRQ_PIN, .EXT_TIMER_PIN, .UPPER_PORT_PINS, .PORT_LATCH, .PERIPH_EVT, .FSR, .DIR_OFFSET,
        .INDIRECT_ADDR, .DIRECT_ADDR, .PULLUP_EN, .TIMER0_TICK, .T0_DIV_LOG2, .WDT_DIV_LOG2, .IRQ_REQ);
    cso_core_bfm cso_core_bfm_i (.CLOCK, .RD_DATA, .ADDR, .WR_EN, .WR_DATA, .ALU, .EVT);

    // clock and tick counter
    always #25 CLOCK = ~CLOCK;
    always @(posedge CLOCK) ticks <= ticks + int'(TIMER0_TICK === 1'b1);

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] dd);
        cso_core_bfm_i.xfer(a, 1'b1, dd, '0, '0, q);
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        cso_core_bfm_i.xfer(a, 1'b0, 8'h00, '0, '0, q);
        chk(q, e);
    endtask

    // expected status after one alu operation; subtract adds the complement
    function automatic logic [7:0] alu_st(input logic [7:0] s, input cso_alu_s x);
        logic [8:0] bb;
        logic [8:0] r;
        logic [4:0] h;
        logic       ci;
        ci = (x.op == CSO_ALU_SUB);
        bb = ci ? {1'b0, ~x.b} : {1'b0, x.b};
        r = {1'b0, x.a} + bb + 9'(ci);
        h = {1'b0, x.a[3:0]} + 5'(bb[3:0]) + 5'(ci);
        case (x.op)
            CSO_ALU_ADD, CSO_ALU_SUB: s[2:0] = {r[7:0] == 8'h00, h[4], r[8]};
            CSO_ALU_LOGIC: s[2] = (x.b == 8'h00);
            CSO_ALU_RLF: s[0] = x.a[7];
            CSO_ALU_RRF: s[0] = x.a[0];
            default: ;
        endcase
        return s;
    endfunction

    task automatic test_done;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // main sequence
    initial begin
        void'($urandom(56952));
        repeat (2) @(posedge CLOCK);
        @(negedge CLOCK);
        RESET = 1'b0;
        for (int k = 0; k < 4; k++) begin
            rd(9'h003 + 9'(k * 128), 8'h18);
            rd(9'h00B + 9'(k * 128), 8'h00);
        end
        rd(9'h181, 8'hFF);
        rd(9'h08C, 8'h00);
        rd(9'h005, 8'h00);
        wr(9'h083, 8'hE7);
        rd(9'h103, 8'hFF);
        wr(9'h183, 8'h00);
        rd(9'h003, 8'h18);
        // bank selects drive both address outputs
        for (int k = 0; k < 8; k++) begin
            FSR = 8'($urandom);
            DIR_OFFSET = 7'($urandom);
            wr(9'h003, {3'(k), 5'h00});
            rd(9'h003, {3'(k), 5'h18});
            chk(DIRECT_ADDR, {k[1:0], DIR_OFFSET});
            chk(INDIRECT_ADDR, {k[2], FSR});
        end
        st = 8'hF8;
        // alu ops, every other one racing a status write
        for (int i = 0; i < 40; i++) begin
            al.op = ops[$urandom_range(4)];
            al.a = 8'($urandom);
            al.b = (i % 5 == 0) ? al.a : 8'($urandom);
            d = 8'($urandom);
            cso_core_bfm_i.xfer(9'h003, i[0], d, al, '0, q);
            if (i[0])
                st = {d[7:5], st[4:3], d[2:0]};
            st = alu_st(st, al);
            rd(9'h083, st);
        end
        // watchdog and sleep events
        foreach (evs[k]) begin
            ev = cso_evt_s'(evs[k]);
            cso_core_bfm_i.xfer(9'h000, 1'b0, 8'h00, '0, ev, q);
            if (ev.wdt_clr)
                st[4:3] = 2'b11;
            if (ev.sleep)
                st[4:3] = 2'b10;
            if (ev.wdt_timeout)
                st[4] = 1'b0;
            rd(9'h003, st);
        end
        // option fields and the controls they produce
        for (int i = 0; i < 24; i++) begin
            d = 8'($urandom);
            PORT_LATCH = 8'($urandom);
            wr(i[0] ? 9'h181 : 9'h081, d);
            rd(9'h081, d);
            chk(PULLUP_EN, d[7] ? 8'h00 : PORT_LATCH);
            chk(T0_DIV_LOG2, d[3] ? 4'h0 : 4'(d[2:0]) + 4'h1);
            chk(WDT_DIV_LOG2, d[3] ? d[2:0] : 3'h0);
            if (!d[5])
                chk(TIMER0_TICK, 1'b1);
        end
        // pin edges: wrong edge first, then the selected one
        for (int s = 0; s < 2; s++) begin
            wr(9'h081, {1'b1, s[0], 1'b1, ~s[0], 4'hF});
            EXT_IRQ_PIN = s[0];
            EXT_TIMER_PIN = s[0];
            repeat (4) @(negedge CLOCK);
            wr(9'h00B, 8'h00);
            n = ticks;
            EXT_IRQ_PIN = ~s[0];
            EXT_TIMER_PIN = ~s[0];
            rd(9'h00B, 8'h00);
            rd(9'h00B, 8'h00);
            chk(9'(ticks - n), 9'h000);
            EXT_IRQ_PIN = s[0];
            EXT_TIMER_PIN = s[0];
            repeat (4) @(negedge CLOCK);
            rd(9'h00B, 8'h02);
            chk(9'(ticks - n), 9'h001);
        end
        // core interrupt flags and the request
        wr(9'h08B, 8'hA8);
        UPPER_PORT_PINS = 4'h5;
        repeat (4) @(negedge CLOCK);
        rd(9'h10B, 8'hA9);
        chk(IRQ_REQ, 1'b1);
        wr(9'h18B, 8'h20);
        cso_core_bfm_i.xfer(9'h00B, 1'b0, 8'h00, '0, cso_evt_s'(4'h1), q);
        rd(9'h00B, 8'h24);
        chk(IRQ_REQ, 1'b0);
        wr(9'h00B, 8'hA4);
        rd(9'h00B, 8'hA4);
        chk(IRQ_REQ, 1'b1);
        // external pair alone raises the request
        wr(9'h00B, 8'h92);
        rd(9'h00B, 8'h92);
        chk(IRQ_REQ, 1'b1);
        // peripheral enables and flags
        wr(9'h08C, 8'hFF);
        rd(9'h08C, 8'hF7);
        wr(9'h00B, 8'h80);
        PERIPH_EVT = 8'h31;
        @(negedge CLOCK);
        PERIPH_EVT = 8'h30;
        rd(9'h00C, 8'h31);
        chk(IRQ_REQ, 1'b0);
        wr(9'h00B, 8'hC0);
        rd(9'h00C, 8'h31);
        chk(IRQ_REQ, 1'b1);
        wr(9'h00C, 8'h00);
        rd(9'h00C, 8'h30);
        PERIPH_EVT = 8'h00;
        rd(9'h00C, 8'h00);
        test_done;
    end

    // cuts a hang short well beyond the expected run length
    initial begin
        repeat (5000) @(posedge CLOCK);
        num_errors++;
        test_done;
    end
endmodule
`default_nettype wire
